// ---- hw/dos_pkg.sv ----
// constants and types shared by the drive operating-state sequencer
// assumes one system clock at 10 MHz and a synchronous active-high reset
package dos_pkg;

    // ========================================================
    // register port
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_OPTIONS = 4'h8;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

    // ========================================================
    // command word bit positions
    localparam int unsigned CW_SWITCH_ON = 0;
    localparam int unsigned CW_ENABLE_VOLTAGE = 1;
    localparam int unsigned CW_QUICK_STOP_N = 2;
    localparam int unsigned CW_ENABLE_OP = 3;
    localparam int unsigned CW_FAULT_RESET = 7;
    localparam int unsigned CW_HALT = 8;

    // ========================================================
    // options register bit positions
    localparam int unsigned OPT_DISABLE_STOP = 0;
    localparam int unsigned OPT_QS_HOLD = 1;
    localparam int unsigned OPT_REF_IN_CHAN = 2;
    localparam int unsigned OPT_W = 3;
    localparam logic [OPT_W-1:0] OPT_RESET = 3'h0;

    // quick_stop_completion_option values
    localparam logic QS_RETURN_AFTER_STOP = 1'b0;
    localparam logic QS_HOLD_AFTER_STOP = 1'b1;

    // ========================================================
    // profile_state_word layout
    localparam int unsigned SW_CODE_LSB = 0;
    localparam int unsigned SW_CODE_MSB = 3;
    localparam int unsigned SW_HALT = 4;
    localparam int unsigned SW_STOPPING = 5;
    localparam int unsigned CODE_W = 4;
    localparam logic [CODE_W-1:0] CODE_HIDDEN = 4'h0;
    localparam logic [CODE_W-1:0] CODE_SW_ON_DISABLED = 4'h2;
    localparam logic [CODE_W-1:0] CODE_READY = 4'h3;
    localparam logic [CODE_W-1:0] CODE_SWITCHED_ON = 4'h4;
    localparam logic [CODE_W-1:0] CODE_OP_ENABLED = 4'h5;
    localparam logic [CODE_W-1:0] CODE_QUICK_STOP = 4'h6;
    localparam logic [CODE_W-1:0] CODE_FAULT_REACT = 4'h7;
    localparam logic [CODE_W-1:0] CODE_FAULT = 4'h8;
    localparam logic [CODE_W-1:0] CODE_INIT = 4'h1;

    // ========================================================
    // operating states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_SW_ON_DISABLED,
        ST_READY,
        ST_SWITCHED_ON,
        ST_OP_ENABLED,
        ST_QUICK_STOP,
        ST_FAULT_REACT,
        ST_FAULT
    } dos_state_t;

endpackage

// ---- hw/dos_sequencer.sv ----
// drive operating-state sequencer: eight-state profile machine that gates
// contactor, power stage, output lock, motor power and parameter writes
// assumes a single clock, synchronous inputs and a master on the plain port
//
// Behaviour
// - state moves on received command words and internal events such as errors
// - current state is readable as a code in the profile state word
// - initialisation state is transient and never reported
// - state 2: locked, no motor power, contactor open, all parameters writable
// - state 3: locked, contactor open; needs power supply before state 4
// - state 4: contactor closed, power stage on, output still locked
// - state 4: adjustment writes allowed; configuration write returns to state 2
// - state 5: output unlocked; no power if reference zero or halt
// - auto tuning only permitted in state 5
// - configuration writes refused in states 5 and 6
// - enable operation only from valid channel, after reference seen if needed
// - disable operation with stop option 0: straight to state 4, freewheel
// - disable operation with stop option 1: ramp down, then state 4
// - state 6 fast stops then locks; restart only through state 2
// - return option: after fast stop go to state 2 by itself
// - hold option: after fast stop stay until disable voltage or stop key
// - an error enters transient state 7 for the error response
// - state 8: power stage off, locked, no motor power
// - fault reset acts only on rising edge; don't-care bits ignored
// - halt stops motion without leaving state 5
//
// Decided for this implementation: the register offsets and the plain strobed port.
module dos_sequencer
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [dos_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dos_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_init_done,
    input wire logic i_power_supplied,
    input wire logic i_chan_valid,
    input wire logic i_ref_received,
    input wire logic i_ref_zero,
    input wire logic i_ramp_stop_done,
    input wire logic i_fast_stop_done,
    input wire logic i_stop_key,
    input wire logic i_error,
    input wire logic i_err_resp_done,
    input wire logic i_err_resp_power,
    input wire logic i_cfg_param_wr,
    output logic [dos_pkg::DATA_W-1:0] o_rd_data,
    output logic [dos_pkg::DATA_W-1:0] o_profile_state_word,
    output logic o_contactor_close,
    output logic o_power_stage_on,
    output logic o_output_unlocked,
    output logic o_motor_power,
    output logic o_cfg_wr_ok,
    output logic o_adj_wr_ok,
    output logic o_autotune_ok,
    output logic o_ramp_stop_req,
    output logic o_fast_stop_req,
    output logic o_freewheel_stop,
    output logic o_halt_active
);
    import dos_pkg::*;
    // ========================================================
    // registers
    dos_state_t state_r, state_nxt;
    logic [DATA_W-1:0] cw_r;
    logic [OPT_W-1:0] opt_r;
    logic ref_seen_r;
    logic wr_ctrl, wr_opt, fault_reset_rise, chan_ok, disable_ramp, qs_hold;
    logic cmd_dis_volt, cmd_quick_stop, cmd_shutdown;
    logic cmd_switch_on, cmd_enable_op, cmd_disable_op;

    assign wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    assign wr_opt = i_wr && (i_addr == ADDR_OPTIONS);
    assign disable_ramp = opt_r[OPT_DISABLE_STOP];
    assign qs_hold = (opt_r[OPT_QS_HOLD] == QS_HOLD_AFTER_STOP);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cw_r <= CTRL_RESET;
        end else if (i_ce && wr_ctrl) begin
            cw_r <= i_wr_data;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            opt_r <= OPT_RESET;
        end else if (i_ce && wr_opt) begin
            opt_r <= i_wr_data[OPT_W-1:0];
        end
    end
    // remembers that the command channel has delivered a reference
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ref_seen_r <= 1'b0;
        end else if (i_ce && i_ref_received) begin
            ref_seen_r <= 1'b1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rd_data <= READ_ZERO;
        end else if (i_ce) begin
            o_rd_data <= READ_ZERO;
            if (i_rd) begin
                unique case (i_addr)
                    ADDR_CTRL: o_rd_data <= cw_r;
                    ADDR_STATUS: o_rd_data <= o_profile_state_word;
                    ADDR_OPTIONS: o_rd_data <= {{(DATA_W-OPT_W){1'b0}}, opt_r};
                    default: o_rd_data <= READ_ZERO;
                endcase
            end
        end
    end
    // ========================================================
    // command decode: only the bits that matter for each command
    assign cmd_dis_volt = !cw_r[CW_ENABLE_VOLTAGE];
    assign cmd_quick_stop = cw_r[CW_ENABLE_VOLTAGE] && !cw_r[CW_QUICK_STOP_N];
    assign cmd_shutdown = cw_r[CW_ENABLE_VOLTAGE] && cw_r[CW_QUICK_STOP_N]
        && !cw_r[CW_SWITCH_ON];
    assign cmd_switch_on = cw_r[CW_ENABLE_VOLTAGE] && cw_r[CW_QUICK_STOP_N]
        && cw_r[CW_SWITCH_ON];
    assign cmd_enable_op = cmd_switch_on && cw_r[CW_ENABLE_OP];
    assign cmd_disable_op = cmd_switch_on && !cw_r[CW_ENABLE_OP];
    assign fault_reset_rise = wr_ctrl && i_wr_data[CW_FAULT_RESET]
        && !cw_r[CW_FAULT_RESET];
    assign chan_ok = i_chan_valid
        && (!opt_r[OPT_REF_IN_CHAN] || ref_seen_r);
    // ========================================================
    // state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_INIT: begin
                if (i_init_done) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end
            end
            ST_SW_ON_DISABLED: begin
                if (cmd_shutdown) begin
                    state_nxt = ST_READY;
                end
            end
            ST_READY: begin
                if (cmd_dis_volt || cmd_quick_stop) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end else if (cmd_switch_on && i_power_supplied) begin
                    state_nxt = ST_SWITCHED_ON;
                end
            end
            ST_SWITCHED_ON: begin
                if (i_cfg_param_wr || cmd_dis_volt || cmd_quick_stop) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end else if (cmd_shutdown) begin
                    state_nxt = ST_READY;
                end else if (cmd_enable_op && chan_ok) begin
                    state_nxt = ST_OP_ENABLED;
                end
            end
            ST_OP_ENABLED: begin
                if (cmd_dis_volt) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end else if (cmd_quick_stop) begin
                    state_nxt = ST_QUICK_STOP;
                end else if (cmd_shutdown) begin
                    state_nxt = ST_READY;
                end else if (cmd_disable_op && !disable_ramp) begin
                    state_nxt = ST_SWITCHED_ON;
                end else if (cmd_disable_op && i_ramp_stop_done) begin
                    state_nxt = ST_SWITCHED_ON;
                end
            end
            ST_QUICK_STOP: begin
                if (cmd_dis_volt) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end else if (i_fast_stop_done && !qs_hold) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end else if (i_fast_stop_done && i_stop_key) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end
            end
            ST_FAULT_REACT: begin
                if (i_err_resp_done) begin
                    state_nxt = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (fault_reset_rise && !i_error) begin
                    state_nxt = ST_SW_ON_DISABLED;
                end
            end
        endcase
        if (i_error && state_r != ST_FAULT_REACT && state_r != ST_FAULT) begin
            state_nxt = ST_FAULT_REACT;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= ST_INIT;
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end
    // ========================================================
    // per-state gating, registered alongside the state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_contactor_close <= 1'b0;
            o_power_stage_on <= 1'b0;
            o_output_unlocked <= 1'b0;
            o_motor_power <= 1'b0;
            o_cfg_wr_ok <= 1'b0;
            o_adj_wr_ok <= 1'b0;
            o_autotune_ok <= 1'b0;
            o_halt_active <= 1'b0;
        end else if (i_ce) begin
            o_contactor_close <= 1'b0;
            o_power_stage_on <= 1'b0;
            o_output_unlocked <= 1'b0;
            o_motor_power <= 1'b0;
            o_cfg_wr_ok <= 1'b0;
            o_adj_wr_ok <= (state_nxt != ST_INIT);
            o_autotune_ok <= 1'b0;
            o_halt_active <= 1'b0;
            unique case (state_nxt)
                ST_INIT: o_cfg_wr_ok <= 1'b0;
                ST_SW_ON_DISABLED: o_cfg_wr_ok <= 1'b1;
                ST_READY: o_cfg_wr_ok <= 1'b1;
                ST_SWITCHED_ON: begin
                    o_contactor_close <= 1'b1;
                    o_power_stage_on <= 1'b1;
                    o_cfg_wr_ok <= 1'b1;
                end
                ST_OP_ENABLED: begin
                    o_contactor_close <= 1'b1;
                    o_power_stage_on <= 1'b1;
                    o_output_unlocked <= 1'b1;
                    o_motor_power <= !i_ref_zero && !cw_r[CW_HALT];
                    o_autotune_ok <= 1'b1;
                    o_halt_active <= cw_r[CW_HALT];
                end
                ST_QUICK_STOP: begin
                    o_contactor_close <= 1'b1;
                    o_power_stage_on <= 1'b1;
                    o_output_unlocked <= !i_fast_stop_done;
                    o_motor_power <= !i_fast_stop_done;
                end
                ST_FAULT_REACT: begin
                    o_contactor_close <= i_err_resp_power;
                    o_power_stage_on <= i_err_resp_power;
                    o_output_unlocked <= i_err_resp_power;
                    o_motor_power <= i_err_resp_power;
                end
                ST_FAULT: o_cfg_wr_ok <= 1'b1;
            endcase
        end
    end
    // stop requests toward the ramp generator
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ramp_stop_req <= 1'b0;
            o_fast_stop_req <= 1'b0;
            o_freewheel_stop <= 1'b0;
        end else if (i_ce) begin
            o_ramp_stop_req <= (state_nxt == ST_OP_ENABLED)
                && cmd_disable_op && disable_ramp;
            o_fast_stop_req <= (state_nxt == ST_QUICK_STOP)
                && !i_fast_stop_done;
            o_freewheel_stop <= (state_r == ST_OP_ENABLED)
                && (state_nxt == ST_SWITCHED_ON) && !disable_ramp;
        end
    end
    // ========================================================
    // status word
    function automatic logic [CODE_W-1:0] state_code(input dos_state_t s);
        logic [CODE_W-1:0] c;
        c = CODE_HIDDEN;
        unique case (s)
            ST_INIT: c = CODE_HIDDEN;
            ST_SW_ON_DISABLED: c = CODE_SW_ON_DISABLED;
            ST_READY: c = CODE_READY;
            ST_SWITCHED_ON: c = CODE_SWITCHED_ON;
            ST_OP_ENABLED: c = CODE_OP_ENABLED;
            ST_QUICK_STOP: c = CODE_QUICK_STOP;
            ST_FAULT_REACT: c = CODE_FAULT_REACT;
            ST_FAULT: c = CODE_FAULT;
        endcase
        return c;
    endfunction
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_profile_state_word <= READ_ZERO;
        end else if (i_ce) begin
            o_profile_state_word <= READ_ZERO;
            o_profile_state_word[SW_CODE_MSB:SW_CODE_LSB] <=
                state_code(state_nxt);
            o_profile_state_word[SW_HALT] <=
                (state_nxt == ST_OP_ENABLED) && cw_r[CW_HALT];
            o_profile_state_word[SW_STOPPING] <=
                (state_nxt == ST_QUICK_STOP) && !i_fast_stop_done;
        end
    end
    // ========================================================
    // checks
    default clocking dos_cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_error_entry: assert property (
        i_ce && i_error && state_r != ST_FAULT && state_r != ST_FAULT_REACT
        |=> state_r == ST_FAULT_REACT)
        else $error("error did not enter fault reaction");
    a_resp_done: assert property (
        i_ce && state_r == ST_FAULT_REACT && i_err_resp_done
        |=> state_r == ST_FAULT
            && o_profile_state_word[SW_CODE_MSB:SW_CODE_LSB] == CODE_FAULT)
        else $error("fault reaction did not finish into fault");
    a_fault_locked: assert property (
        state_r == ST_FAULT |-> !o_power_stage_on && !o_output_unlocked
            && !o_motor_power)
        else $error("fault state not locked");
    a_fault_sticky: assert property (
        i_ce && state_r == ST_FAULT && !fault_reset_rise
        |=> state_r == ST_FAULT)
        else $error("fault left without reset edge");
    a_init_hidden: assert property (
        o_profile_state_word[SW_CODE_MSB:SW_CODE_LSB] != CODE_INIT)
        else $error("initialisation state reported");
    a_code_match: assert property (
        state_r == ST_OP_ENABLED
        |-> o_profile_state_word[SW_CODE_MSB:SW_CODE_LSB] == CODE_OP_ENABLED)
        else $error("status code does not match state");
    a_disabled_open: assert property (
        state_r == ST_SW_ON_DISABLED |-> !o_contactor_close
            && !o_motor_power && o_cfg_wr_ok && o_adj_wr_ok)
        else $error("state 2 gating wrong");
    a_ready_wait: assert property (
        i_ce && state_r == ST_READY && !i_power_supplied && !i_error
        |=> state_r != ST_SWITCHED_ON && !o_contactor_close)
        else $error("switched on without power supply");
    a_switched_lock: assert property (
        state_r == ST_SWITCHED_ON |-> o_contactor_close && o_power_stage_on
            && !o_output_unlocked)
        else $error("state 4 gating wrong");
    a_cfg_return: assert property (
        i_ce && state_r == ST_SWITCHED_ON && i_cfg_param_wr && !i_error
        |=> state_r == ST_SW_ON_DISABLED)
        else $error("configuration write did not return to state 2");
    a_run_power: assert property (
        o_motor_power && state_r == ST_OP_ENABLED |-> o_output_unlocked
            && !o_halt_active)
        else $error("motor power while halted");
    a_tune_gate: assert property (
        o_autotune_ok |-> state_r == ST_OP_ENABLED)
        else $error("tuning outside state 5");
    a_cfg_block: assert property (
        state_r == ST_OP_ENABLED || state_r == ST_QUICK_STOP
        |-> !o_cfg_wr_ok && o_adj_wr_ok)
        else $error("configuration writable while running");
    a_enable_gate: assert property (
        i_ce && state_r == ST_SWITCHED_ON && !chan_ok
        |=> state_r != ST_OP_ENABLED)
        else $error("enabled without valid channel");
    a_free_stop: assert property (
        i_ce && state_r == ST_OP_ENABLED && cmd_disable_op && !disable_ramp
        && !i_error |=> state_r == ST_SWITCHED_ON && o_freewheel_stop)
        else $error("freewheel disable not immediate");
    a_ramp_wait: assert property (
        i_ce && state_r == ST_OP_ENABLED && cmd_disable_op && disable_ramp
        && !i_ramp_stop_done && !i_error
        |=> state_r == ST_OP_ENABLED && o_ramp_stop_req)
        else $error("ramp disable left before ramp done");
    a_qs_norestart: assert property (
        i_ce && state_r == ST_QUICK_STOP
        |=> state_r != ST_OP_ENABLED && state_r != ST_SWITCHED_ON)
        else $error("restart straight from quick stop");
    a_qs_return: assert property (
        i_ce && state_r == ST_QUICK_STOP && i_fast_stop_done && !qs_hold
        && !i_error |=> state_r == ST_SW_ON_DISABLED)
        else $error("return option did not go to state 2");
    a_qs_hold: assert property (
        i_ce && state_r == ST_QUICK_STOP && qs_hold && !i_stop_key
        && !cmd_dis_volt && !i_error |=> state_r == ST_QUICK_STOP)
        else $error("hold option left quick stop");
    a_halt_stays: assert property (
        i_ce && state_r == ST_OP_ENABLED && cmd_enable_op && cw_r[CW_HALT]
        && !i_error |=> state_r == ST_OP_ENABLED && o_halt_active)
        else $error("halt left state 5");
    a_cmd_move: assert property (
        i_ce && state_r == ST_SW_ON_DISABLED && cmd_shutdown && !i_error
        |=> state_r == ST_READY)
        else $error("shutdown command ignored");
    c_run: cover property (state_r == ST_SWITCHED_ON ##1
        state_r == ST_OP_ENABLED);
    c_quick: cover property (state_r == ST_QUICK_STOP ##1
        state_r == ST_SW_ON_DISABLED);
    c_fault: cover property (state_r == ST_FAULT ##1
        state_r == ST_SW_ON_DISABLED);
    c_ramp: cover property (o_ramp_stop_req ##1 state_r == ST_SWITCHED_ON);
endmodule

// ---- tb/dos_master.sv ----
// fieldbus master model: writes command words and reads the plain port
// assumes the one-cycle strobe port of the sequencer, no wait states
module dos_master
    import dos_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [dos_pkg::DATA_W-1:0] i_rd_data,
    output logic [dos_pkg::ADDR_W-1:0] o_addr,
    output logic [dos_pkg::DATA_W-1:0] o_wr_data,
    output logic o_wr,
    output logic o_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    import dos_pkg::*;
    initial begin
        o_addr = '0;
        o_wr_data = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // ========================================================
    // bus cycles; released lines show the inverse of the last value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wr_data <= d;
        o_wr <= 1'b1;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wr_data <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clk_sys);
        d = i_rd_data;
    endtask
endmodule

// ---- tb/drive_operating_state_machine_test.sv ----
// self-checking bench of the operating-state sequencer
// assumes the master model drives the register port
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module drive_operating_state_machine_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dos_pkg::*;
    logic clk = 0, rst = 1, ini = 0, pwr = 0, chv = 0, refr = 0, refz = 0;
    logic rdn = 0, fsd = 0, err = 0, erd = 0, cfg = 0;
    logic ce = 1'b1, sk = 1'b0, erp = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdd, psw, v;
    logic wr, rd, cc, ps, ul, mp, cok, aok, at, rsr, fsr, fw, ha;
    int fails = 0, checks = 0, fw_n = 0;
    logic [15:0] seed = 16'h0036;
    always #50 clk = ~clk;
    always @(posedge clk) if (fw === 1'b1) fw_n++;
    dos_master m (.i_clk_sys(clk), .i_rd_data(rdd), .o_addr(addr),
        .o_wr_data(wd), .o_wr(wr), .o_rd(rd));
    dos_sequencer dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
        .i_addr(addr), .i_wr_data(wd), .i_wr(wr), .i_rd(rd),
        .i_init_done(ini), .i_power_supplied(pwr), .i_chan_valid(chv),
        .i_ref_received(refr), .i_ref_zero(refz), .i_ramp_stop_done(rdn),
        .i_fast_stop_done(fsd), .i_stop_key(sk), .i_error(err),
        .i_err_resp_done(erd), .i_err_resp_power(erp),
        .i_cfg_param_wr(cfg), .o_rd_data(rdd), .o_profile_state_word(psw),
        .o_contactor_close(cc), .o_power_stage_on(ps),
        .o_output_unlocked(ul), .o_motor_power(mp), .o_cfg_wr_ok(cok),
        .o_adj_wr_ok(aok), .o_autotune_ok(at), .o_ramp_stop_req(rsr),
        .o_fast_stop_req(fsr), .o_freewheel_stop(fw), .o_halt_active(ha));
    // ========================================================
    // expectation and stimulus helpers
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction
    function automatic logic [15:0] exp_word(logic [3:0] c, logic h, logic s);
        return {10'h000, s, h, c};
    endfunction
    // reserved and assignable bits are randomised: they must not matter
    task automatic cmd(input logic [15:0] c);
        m.wr(ADDR_CTRL, c | (xs() & 16'hf870));
        repeat (3) @(posedge clk);
    endtask
    task automatic hold3();
        repeat (3) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #(5000 * 100);
        fails++;
        summarize();
    end
    // ========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        `CHK(psw, 16'h0000)
        `CHK(cc, 1'b0)
        rst <= 1'b0;
        hold3();
        `CHK(psw[3:0], CODE_HIDDEN)
        ini <= 1'b1;
        hold3();
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        `CHK({cc, mp, ul, cok, aok}, 5'b00011)
        ce <= 1'b0;
        cmd(16'h0006);
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        ce <= 1'b1;
        cmd(16'h0006);
        `CHK({psw[3:0], cc, cok}, {CODE_READY, 2'b01})
        cmd(16'h0007);
        `CHK(psw[3:0], CODE_READY)
        pwr <= 1'b1;
        cmd(16'h0007);
        `CHK({psw[3:0], cc, ps, ul, mp}, {CODE_SWITCHED_ON, 4'b1100})
        `CHK(aok, 1'b1)
        @(posedge clk) cfg <= 1'b1;
        @(posedge clk) cfg <= 1'b0;
        hold3();
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        cmd(16'h0006);
        cmd(16'h0007);
        m.wr(ADDR_OPTIONS, 16'h0004);
        cmd(16'h000f);
        `CHK(psw[3:0], CODE_SWITCHED_ON)
        chv <= 1'b1;
        cmd(16'h000f);
        `CHK(psw[3:0], CODE_SWITCHED_ON)
        refr <= 1'b1;
        cmd(16'h000f);
        `CHK({psw[3:0], ul, mp, at}, {CODE_OP_ENABLED, 3'b111})
        `CHK({cok, aok}, 2'b01)
        refz <= 1'b1;
        hold3();
        `CHK(mp, 1'b0)
        refz <= 1'b0;
        cmd(16'h010f);
        `CHK({psw[3:0], ha, mp}, {CODE_OP_ENABLED, 2'b10})
        m.rd(ADDR_STATUS, v);
        `CHK(v, exp_word(CODE_OP_ENABLED, 1'b1, 1'b0))
        cmd(16'h0007);
        `CHK(psw[3:0], CODE_SWITCHED_ON)
        m.wr(ADDR_OPTIONS, 16'h0005);
        cmd(16'h000f);
        cmd(16'h0007);
        `CHK({psw[3:0], rsr}, {CODE_OP_ENABLED, 1'b1})
        rdn <= 1'b1;
        hold3();
        `CHK(psw[3:0], CODE_SWITCHED_ON)
        rdn <= 1'b0;
        cmd(16'h000f);
        cmd(16'h0002);
        `CHK({psw[3:0], fsr, cok}, {CODE_QUICK_STOP, 2'b10})
        fsd <= 1'b1;
        hold3();
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        fsd <= 1'b0;
        m.wr(ADDR_OPTIONS, 16'h0006);
        cmd(16'h0006);
        cmd(16'h0007);
        cmd(16'h000f);
        cmd(16'h0002);
        fsd <= 1'b1;
        hold3();
        `CHK(psw[3:0], CODE_QUICK_STOP)
        cmd(16'h0000);
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        cmd(16'h0006);
        cmd(16'h0007);
        cmd(16'h000f);
        cmd(16'h0002);
        `CHK(psw[3:0], CODE_QUICK_STOP)
        sk <= 1'b1;
        hold3();
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        sk <= 1'b0;
        fsd <= 1'b0;
        err <= 1'b1;
        erp <= 1'b1;
        hold3();
        `CHK({psw[3:0], cc, mp}, {CODE_FAULT_REACT, 2'b11})
        erd <= 1'b1;
        hold3();
        `CHK({psw[3:0], ps, ul, mp}, {CODE_FAULT, 3'b000})
        cmd(16'h0080);
        err <= 1'b0;
        erd <= 1'b0;
        cmd(16'h0080);
        `CHK(psw[3:0], CODE_FAULT)
        cmd(16'h0000);
        cmd(16'h0080);
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        rst <= 1'b1;
        hold3();
        `CHK({psw, cc, aok}, 18'h00000)
        rst <= 1'b0;
        hold3();
        `CHK(psw[3:0], CODE_SW_ON_DISABLED)
        m.rd(4'hc, v);
        `CHK(v, READ_ZERO)
        `CHK(fw_n, 1)
        summarize();
    end
endmodule
